// file: image_store.sv
// partner model: memory holding the bulk context image
// assumes one word per cycle, read combinationally by index
`timescale 1ns/1ps
`include "lazy_fp_consts.vh"
module image_store (
    // image port of the trap block
    input wire clk_i,
    input wire image_we_o,
    input wire [`VEC_IDX_WIDTH-1:0] image_idx_o,
    input wire [`VEC_WIDTH-1:0] image_wdata_o,
    output wire [`VEC_WIDTH-1:0] image_rdata_i
);
    logic [`VEC_WIDTH-1:0] mem [0:8];
    always @(posedge clk_i) begin
        if (image_we_o) begin
            mem[image_idx_o] <= image_wdata_o;
        end
    end
    // an index past the image reads inverted data so it never looks valid
    assign image_rdata_i = (image_idx_o < 9) ? mem[image_idx_o] : ~mem[0];
endmodule // image_store

// file: lazy_fp_consts.vh
// constants for the lazy floating-point context trap block
// assumes an including module that works on a 32-bit control register zero
`ifndef LAZY_FP_CONSTS_VH
`define LAZY_FP_CONSTS_VH
`define CR0_WIDTH 32
`define CR0_EM_BIT 2
`define CR0_TS_BIT 3
`define CR0_RESET_VALUE 32'h0000_0010
// instruction class codes from the decoder
`define CLS_WIDTH 4
`define CLS_GENERAL 4'h0
`define CLS_FLOAT 4'h1
`define CLS_PACKED_INT 4'h2
`define CLS_VECTOR 4'h3
`define CLS_VEC_CSR 4'h4
`define CLS_CHECKSUM 4'h5
`define CLS_BITCOUNT 4'h6
`define CLS_BULK_SAVE 4'h7
`define CLS_BULK_RESTORE 4'h8
`define CLS_MOVE_TO_CR0 4'h9
`define CLS_CLEAR_SWITCH 4'hA
// bulk image layout: vector data registers then the control/status word
`define VEC_REGS 8
`define VEC_WIDTH 32
`define VEC_IDX_WIDTH 4
`endif

// file: lazy_fp_context_trap.v
// trap logic for lazy floating-point and vector context switching
// assumes an in-order core: one decoded instruction offered per cycle with a
// valid/class pair, retired only when this block answers without a fault
`timescale 1ns/1ps
`include "lazy_fp_consts.vh"

// Behaviour
// RULE1 - while the switched flag is set, a context-touching instruction faults before it executes.
// RULE2 - access to float, packed, vector or vector status registers with the flag at 1 faults.
// RULE3 - a native hardware task switch sets the switched flag.
// RULE4 - a move to control register zero can set the switched flag.
// RULE5 - a dedicated instruction clears the flag, which the handler runs after saving.
// RULE6 - checksum and bit-count instructions never fault on the switched flag.
// RULE7 - bulk save writes the whole context out, bulk restore reloads it from such an image.
// RULE8 - the vector context is the vector data registers plus the control/status word.
// RULE9 - the operating system sets the flag to 1 or 0 by ownership on each switch.
// RULE10 - the handler saves, restores, records the owner and clears the flag.
// RULE11 - a task that never touches the context never sees the fault.
// RULE12 - the switched flag is bit 3 of control register zero.
// RULE13 - with the emulation flag at bit 2 set, vector instructions give invalid opcode instead.
// RULE14 - the fault is precise: the faulting instruction changes nothing and re-executes.
module lazy_fp_context_trap #(
    parameter VEC_REGS = `VEC_REGS,
    parameter VEC_WIDTH = `VEC_WIDTH
) (
    // clock and reset
    input wire clk_i,
    input wire reset_i,
    input wire ce_i,
    // decoded instruction
    input wire insn_valid_i,
    input wire [`CLS_WIDTH-1:0] insn_class_i,
    input wire [`CR0_WIDTH-1:0] insn_operand_i,
    input wire task_switch_i,
    // register access by vector instructions
    input wire vec_wr_i,
    input wire [`VEC_IDX_WIDTH-1:0] vec_idx_i,
    input wire [VEC_WIDTH-1:0] vec_wdata_i,
    // bulk image stream
    input wire [VEC_WIDTH-1:0] image_rdata_i,
    output reg image_we_o,
    output reg [`VEC_IDX_WIDTH-1:0] image_idx_o,
    output reg [VEC_WIDTH-1:0] image_wdata_o,
    output reg bulk_busy_o,
    // results
    output reg [`CR0_WIDTH-1:0] control_register_zero_o,
    output reg device_unavailable_fault_o,
    output reg invalid_opcode_fault_o,
    output reg retire_o,
    output reg [VEC_WIDTH-1:0] vec_rdata_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_SAVE = 2'd1;
    localparam ST_LOAD = 2'd2;
    localparam [`VEC_IDX_WIDTH-1:0] LAST_IDX = VEC_REGS[`VEC_IDX_WIDTH-1:0];

    // true for classes that read or write the floating/vector context
    function touches_context;
        input [`CLS_WIDTH-1:0] cls;
        begin
            touches_context = (cls == `CLS_FLOAT) || (cls == `CLS_PACKED_INT) ||
                (cls == `CLS_VECTOR) || (cls == `CLS_VEC_CSR) ||
                (cls == `CLS_BULK_SAVE) || (cls == `CLS_BULK_RESTORE);
        end
    endfunction

    // true for vector extension classes, which cannot be emulated
    function is_vector_ext;
        input [`CLS_WIDTH-1:0] cls;
        begin
            is_vector_ext = (cls == `CLS_VECTOR) || (cls == `CLS_VEC_CSR) ||
                (cls == `CLS_BULK_SAVE) || (cls == `CLS_BULK_RESTORE);
        end
    endfunction

    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg [`VEC_IDX_WIDTH-1:0] idx_ff;
    reg [`VEC_IDX_WIDTH-1:0] nxt_idx;
    reg load_pend_ff;
    reg save_pend_ff;
    reg [`VEC_IDX_WIDTH-1:0] idx_d_ff;
    wire task_switched_flag;
    wire emulation_flag;
    wire take_ud;
    wire take_nm;
    wire go;
    wire mem_we;
    wire [`VEC_IDX_WIDTH-1:0] mem_waddr;
    wire [`VEC_IDX_WIDTH-1:0] mem_raddr;
    wire [VEC_WIDTH-1:0] mem_wdata;
    wire [VEC_WIDTH-1:0] mem_rdata;

    // RULE12 flag position
    assign task_switched_flag = control_register_zero_o[`CR0_TS_BIT];
    assign emulation_flag = control_register_zero_o[`CR0_EM_BIT];
    // RULE13 emulation beats switched
    assign take_ud = insn_valid_i && emulation_flag && is_vector_ext(insn_class_i);
    // RULE1 fault before execute
    // RULE2 context registers guarded
    // RULE6 checksum and bitcount exempt
    // RULE11 no touch, no fault
    assign take_nm = insn_valid_i && !take_ud && task_switched_flag &&
        touches_context(insn_class_i);
    // RULE14 faulting instruction blocked
    assign go = insn_valid_i && !take_ud && !take_nm && (state_ff == ST_IDLE);

    // RULE8 vector registers plus status word share one store, status at last index
    assign mem_we = (go && (insn_class_i == `CLS_VECTOR) && vec_wr_i) ||
        (go && (insn_class_i == `CLS_VEC_CSR) && vec_wr_i) || load_pend_ff;
    assign mem_waddr = load_pend_ff ? image_idx_o :
        ((insn_class_i == `CLS_VEC_CSR) ? LAST_IDX : vec_idx_i);
    assign mem_wdata = load_pend_ff ? image_rdata_i : vec_wdata_i;
    assign mem_raddr = (state_ff == ST_SAVE) ? idx_ff :
        ((insn_class_i == `CLS_VEC_CSR) ? LAST_IDX : vec_idx_i);

    vec_state_mem #(
        .DEPTH(VEC_REGS + 1),
        .WIDTH(VEC_WIDTH),
        .AW(`VEC_IDX_WIDTH)
    ) u_state (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .wr_en_i(mem_we),
        .wr_addr_i(mem_waddr),
        .wr_data_i(mem_wdata),
        .rd_addr_i(mem_raddr),
        .rd_data_o(mem_rdata)
    );

    // bulk sequencer: one word per cycle, busy stalls the decoder
    always @* begin
        nxt_state = state_ff;
        nxt_idx = idx_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_idx = {`VEC_IDX_WIDTH{1'b0}};
                // RULE7 start bulk transfer
                if (go && insn_class_i == `CLS_BULK_SAVE) begin
                    nxt_state = ST_SAVE;
                end else if (go && insn_class_i == `CLS_BULK_RESTORE) begin
                    nxt_state = ST_LOAD;
                end
            end
            ST_SAVE, ST_LOAD: begin
                if (idx_ff == LAST_IDX) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_idx = idx_ff + 1'b1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // sequencer and image port registers
    always @(posedge clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            idx_ff <= {`VEC_IDX_WIDTH{1'b0}};
            load_pend_ff <= 1'b0;
            save_pend_ff <= 1'b0;
            idx_d_ff <= {`VEC_IDX_WIDTH{1'b0}};
            image_we_o <= 1'b0;
            image_idx_o <= {`VEC_IDX_WIDTH{1'b0}};
            image_wdata_o <= {VEC_WIDTH{1'b0}};
            bulk_busy_o <= 1'b0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            idx_ff <= nxt_idx;
            bulk_busy_o <= (nxt_state != ST_IDLE);
            // RULE7 save streams out one cycle behind the registered memory read,
            // so the index is delayed too, else every word lands one slot high
            save_pend_ff <= (state_ff == ST_SAVE);
            idx_d_ff <= idx_ff;
            image_we_o <= save_pend_ff;
            image_wdata_o <= mem_rdata;
            // RULE7 restore takes image word one cycle after its index
            load_pend_ff <= (state_ff == ST_LOAD);
            image_idx_o <= save_pend_ff ? idx_d_ff : idx_ff;
        end
    end

    // control register zero and fault reporting
    always @(posedge clk_i) begin
        if (reset_i) begin
            control_register_zero_o <= `CR0_RESET_VALUE;
            device_unavailable_fault_o <= 1'b0;
            invalid_opcode_fault_o <= 1'b0;
            retire_o <= 1'b0;
            vec_rdata_o <= {VEC_WIDTH{1'b0}};
        end else if (ce_i) begin
            device_unavailable_fault_o <= take_nm;
            invalid_opcode_fault_o <= take_ud;
            retire_o <= go;
            vec_rdata_o <= mem_rdata;
            // RULE4 explicit write
            if (go && insn_class_i == `CLS_MOVE_TO_CR0) begin
                control_register_zero_o <= insn_operand_i;
            // RULE5 dedicated clear
            end else if (go && insn_class_i == `CLS_CLEAR_SWITCH) begin
                control_register_zero_o[`CR0_TS_BIT] <= 1'b0;
            end
            // RULE3 native switch sets flag, wins over a clear in the same cycle
            if (task_switch_i) begin
                control_register_zero_o[`CR0_TS_BIT] <= 1'b1;
            end
        end
    end
endmodule // lazy_fp_context_trap

// file: lazy_fp_context_trap_chk.sv
// checker for the trap block: fault, flag and retire relations
// assumes a bind to the trap top, seeing only its ports
`timescale 1ns/1ps
`include "lazy_fp_consts.vh"
module lazy_fp_context_trap_chk (
    // watched ports
    input wire clk_i,
    input wire reset_i,
    input wire ce_i,
    input wire insn_valid_i,
    input wire [`CLS_WIDTH-1:0] insn_class_i,
    input wire [`CR0_WIDTH-1:0] insn_operand_i,
    input wire task_switch_i,
    input wire [`CR0_WIDTH-1:0] control_register_zero_o,
    input wire device_unavailable_fault_o,
    input wire invalid_opcode_fault_o,
    input wire retire_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    // offer decode; ctx marks classes that touch the saved context
    wire go = ce_i && insn_valid_i;
    wire ctx = insn_class_i inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8};
    wire vx = insn_class_i inside {4'h3, 4'h4, 4'h7, 4'h8};
    wire ts = control_register_zero_o[3];
    wire em = control_register_zero_o[2];
    ts_fault_a: assert property (go && ctx && ts && !em |=> device_unavailable_fault_o)
        else $error("context use under flag not trapped");
    reg_access_a: assert property (go && ts && insn_class_i inside {4'h1, 4'h2} |=> !retire_o)
        else $error("register access under flag retired");
    hw_switch_a: assert property (ce_i && task_switch_i |=> ts)
        else $error("task switch left flag clear");
    move_set_a: assert property (go && insn_class_i == 4'h9 && !task_switch_i
        |=> control_register_zero_o == $past(insn_operand_i)) else $error("move not written");
    clear_flag_a: assert property (go && insn_class_i == 4'hA && !task_switch_i |=> !ts)
        else $error("clear left flag set");
    exempt_a: assert property (go && insn_class_i inside {4'h5, 4'h6} |=> retire_o)
        else $error("checksum or bit count did not retire");
    em_wins_a: assert property (go && vx && em |=> invalid_opcode_fault_o)
        else $error("emulation flag not honoured");
    precise_a: assert property (go && ctx && ts && !task_switch_i |=> $stable(control_register_zero_o))
        else $error("faulting offer changed state");
    cover property (go && ctx && ts);
    cover property (go && vx && em);
    cover property (ce_i && task_switch_i);
endmodule // lazy_fp_context_trap_chk

// file: tb_lazy_fp_context_trap.sv
// testbench for the trap block with an image memory partner
// assumes the checker is bound below; clock enable held high
`timescale 1ns/1ps
`include "lazy_fp_consts.vh"
module tb_lazy_fp_context_trap;
    logic clk_i = 0, reset_i = 1, insn_valid_i = 0, task_switch_i = 0, vec_wr_i = 0;
    logic [3:0] insn_class_i = 0, vec_idx_i = 0, image_idx_o;
    logic [31:0] insn_operand_i = 0, vec_wdata_i = 0, image_rdata_i, image_wdata_o;
    logic [31:0] control_register_zero_o, vec_rdata_o;
    logic image_we_o, bulk_busy_o, device_unavailable_fault_o, invalid_opcode_fault_o, retire_o;
    int n_fail = 0, comparisons = 0;
    always #2 clk_i = ~clk_i;
    lazy_fp_context_trap i_dut (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .ce_i(1'b1),
        .insn_valid_i(insn_valid_i),
        .insn_class_i(insn_class_i),
        .insn_operand_i(insn_operand_i),
        .task_switch_i(task_switch_i),
        .vec_wr_i(vec_wr_i),
        .vec_idx_i(vec_idx_i),
        .vec_wdata_i(vec_wdata_i),
        .image_rdata_i(image_rdata_i),
        .image_we_o(image_we_o),
        .image_idx_o(image_idx_o),
        .image_wdata_o(image_wdata_o),
        .bulk_busy_o(bulk_busy_o),
        .control_register_zero_o(control_register_zero_o),
        .device_unavailable_fault_o(device_unavailable_fault_o),
        .invalid_opcode_fault_o(invalid_opcode_fault_o),
        .retire_o(retire_o),
        .vec_rdata_o(vec_rdata_o)
    );
    image_store i_mem (
        .clk_i(clk_i),
        .image_we_o(image_we_o),
        .image_idx_o(image_idx_o),
        .image_wdata_o(image_wdata_o),
        .image_rdata_i(image_rdata_i)
    );
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one offer; k picks retire, device fault or opcode fault
    task run(input logic [3:0] c, input logic [31:0] d, input int k);
        @(posedge clk_i);
        #1;
        insn_valid_i = 1;
        insn_class_i = c;
        insn_operand_i = d;
        @(posedge clk_i);
        #1;
        insn_valid_i = 0;
        vec_wr_i = 0;
        chk(32'({retire_o, device_unavailable_fault_o, invalid_opcode_fault_o}), 32'(3'b100 >> k));
    endtask
    task wait_idle;
        for (int i = 0; i < 40 && bulk_busy_o !== 1'b0; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk(32'(bulk_busy_o), 32'h0000_0000);
        repeat (3) @(posedge clk_i);
        #1;
    endtask
    task t_flags;
        chk(control_register_zero_o, 32'h0000_0010);
        run(4'h9, 32'h0000_0018, 0);
        chk(control_register_zero_o, 32'h0000_0018);
        run(4'hA, 0, 0);
        chk(control_register_zero_o, 32'h0000_0010);
        task_switch_i = 1;
        @(posedge clk_i);
        #1;
        task_switch_i = 0;
        chk(control_register_zero_o, 32'h0000_0018);
        // switch and clear in one cycle: the switch must win
        task_switch_i = 1;
        run(4'hA, 0, 0);
        task_switch_i = 0;
        chk(control_register_zero_o, 32'h0000_0018);
        $display("flags done");
    endtask
    task t_classes;
        for (int c = 0; c < 9; c++) begin
            run(4'(c), 0, (c inside {1, 2, 3, 4, 7, 8}) ? 1 : 0);
        end
        $display("classes done");
    endtask
    task t_emul;
        run(4'h9, 32'h0000_001C, 0);
        run(4'h3, 0, 2);
        run(4'h8, 0, 2);
        run(4'h1, 0, 1);
        run(4'h5, 0, 0);
        run(4'h9, 32'h0000_0010, 0);
        $display("emulation done");
    endtask
    task t_bulk;
        vec_wr_i = 1;
        vec_idx_i = 5;
        vec_wdata_i = 32'hA5A5_0005;
        run(4'h3, 0, 0);
        vec_wr_i = 1;
        vec_wdata_i = 32'h0000_0C08;
        run(4'h4, 0, 0);
        run(4'h7, 0, 0);
        chk(32'(bulk_busy_o), 32'h0000_0001);
        wait_idle;
        chk(i_mem.mem[5], 32'hA5A5_0005);
        chk(i_mem.mem[8], 32'h0000_0C08);
        i_mem.mem[2] = 32'h0000_5A02;
        run(4'h8, 0, 0);
        wait_idle;
        vec_idx_i = 2;
        run(4'h3, 0, 0);
        @(posedge clk_i);
        #1;
        chk(vec_rdata_o, 32'h0000_5A02);
        run(4'h9, 32'h0000_0018, 0);
        vec_wr_i = 1;
        vec_idx_i = 5;
        vec_wdata_i = 32'hFFFF_0000;
        run(4'h3, 0, 1);
        run(4'hA, 0, 0);
        run(4'h3, 0, 0);
        @(posedge clk_i);
        #1;
        chk(vec_rdata_o, 32'hA5A5_0005);
        $display("bulk done");
    endtask
    task end_sim;
        $display("comparisons %0d failures %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        reset_i = 0;
        t_flags;
        t_classes;
        t_emul;
        t_bulk;
        end_sim;
    end
    // watchdog: the tests need well under 300 cycles
    initial begin
        #20000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim;
    end
endmodule // tb_lazy_fp_context_trap
bind lazy_fp_context_trap lazy_fp_context_trap_chk i_chk (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .insn_valid_i(insn_valid_i),
    .insn_class_i(insn_class_i),
    .insn_operand_i(insn_operand_i),
    .task_switch_i(task_switch_i),
    .control_register_zero_o(control_register_zero_o),
    .device_unavailable_fault_o(device_unavailable_fault_o),
    .invalid_opcode_fault_o(invalid_opcode_fault_o),
    .retire_o(retire_o)
);

// file: vec_state_mem.v
// small register-file memory holding vector data registers and control/status
// assumes one write and one read port on the core clock; read data registered
`timescale 1ns/1ps
module vec_state_mem #(
    parameter DEPTH = 9,
    parameter WIDTH = 32,
    parameter AW = 4
) (
    // clock
    input wire clk_i,
    input wire ce_i,
    // write port
    input wire wr_en_i,
    input wire [AW-1:0] wr_addr_i,
    input wire [WIDTH-1:0] wr_data_i,
    // read port
    input wire [AW-1:0] rd_addr_i,
    output reg [WIDTH-1:0] rd_data_o
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];

    // no reset on storage: contents are architecturally undefined until written
    always @(posedge clk_i) begin
        if (ce_i) begin
            if (wr_en_i) begin
                mem_ff[wr_addr_i] <= wr_data_i;
            end
            rd_data_o <= mem_ff[rd_addr_i];
        end
    end
endmodule // vec_state_mem
